// file: hdl/ufc_fifo_control.sv
// FIFO control for one UART channel with APB register access
// Contract
// - Enable bit enables both FIFOs, reset disabled.
// - Receive clear empties FIFO, self-clears.
// - Transmit clear empties FIFO, self-clears.
// - Receive field selects 8/16/24/28 bytes.
// - Transmit field selects 16/8/24/30 bytes.
// - Receive-ready interrupt at receive threshold.
// - Transmit-empty interrupt below transmit threshold.
// - Thresholds also drive flow control.
// - Nonzero extended registers override two-bit fields.
// - Receive-ready withdrawn below receive threshold.
//
// Chosen here: the register addresses and register access over APB.
module ufc_fifo_control
  import ufc_pkg::*;
(
  input  wire logic        pclk,           // Clock, 125 MHz
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        clk_en,         // Clock enable, freezes all state
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  input  wire logic [3:0]  pstrb,          // APB byte strobes
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error, unmapped address
  input  wire logic [7:0]  rx_count,       // Receive FIFO fill count
  input  wire logic [7:0]  tx_count,       // Transmit FIFO fill count
  output logic             fifo_enable,    // Both FIFOs enabled
  output logic             rx_clear,       // Pulse: empty receive FIFO
  output logic             tx_clear,       // Pulse: empty transmit FIFO
  output logic             rx_ready_irq,   // Receive-ready condition
  output logic             tx_empty_irq,   // Transmit-empty condition
  output logic [7:0]       rx_flow_level,  // Selected receive-ready threshold
  output logic [7:0]       flow_high_level,// Flow high threshold
  output logic [7:0]       flow_low_level, // Flow low threshold
  output logic             irq             // Interrupt, active high level
);
  // Whole state of the module
  typedef struct packed {
    ufc_apb_state_t apb;
    logic [7:0]     ctrl;
    ufc_levels_t    levels;
    logic [3:0]     irq_stat;
    logic [3:0]     irq_mask;
    logic           rx_rdy_d;
    logic           tx_emp_d;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           fifo_en;
    logic           rx_clr;
    logic           tx_clr;
    logic           rx_irq;
    logic           tx_irq;
    logic [7:0]     rx_flow;
    logic [7:0]     flow_hi;
    logic [7:0]     flow_lo;
    logic           irq;
  } ufc_state_t;

  ufc_state_t  st_reg;
  ufc_state_t  st_next;
  ufc_thresh_t thresh;

  // Threshold selection from the live register contents
  ufc_thresh_sel u_sel (
    .fifo_control (st_reg.ctrl),
    .levels       (st_reg.levels),
    .thresh       (thresh)
  );

  // Address decode used for both reads and writes
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      UFC_OFF_FIFO_CONTROL, UFC_OFF_RX_IRQ_LEVEL, UFC_OFF_TX_IRQ_LEVEL,
      UFC_OFF_FLOW_HIGH, UFC_OFF_FLOW_LOW, UFC_OFF_STATUS,
      UFC_OFF_IRQ_STATUS, UFC_OFF_IRQ_MASK, UFC_OFF_THRESH: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  logic       acc;
  logic       wr;
  logic       rd;
  logic       rx_rdy;
  logic       tx_emp;
  logic [3:0] events;
  logic [7:0] ctrl_rd;

  // Next-state logic
  always_comb
  begin
    st_next = st_reg;
    acc     = psel && penable && st_reg.pready;
    wr      = acc && pwrite && addr_ok(paddr) && pstrb[0];
    rd      = acc && !pwrite;
    // Clear bits never read back as one; they are pulses only
    ctrl_rd = st_reg.ctrl;
    ctrl_rd[UFC_BIT_RX_CLEAR] = 1'b0;
    ctrl_rd[UFC_BIT_TX_CLEAR] = 1'b0;

    // Conditions compare fill counts with the selected thresholds;
    // a clear forces the counts to read empty for that cycle
    rx_rdy = st_reg.ctrl[UFC_BIT_ENABLE] && !st_reg.rx_clr
             && (rx_count >= thresh.rx);
    tx_emp = st_reg.ctrl[UFC_BIT_ENABLE]
             && (st_reg.tx_clr || (tx_count < thresh.tx));

    // APB: no wait state, ready answers in the first access-phase cycle
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    case (st_reg.apb)
      UFC_IDLE:
      begin
        if (psel && !penable)
        begin
          st_next.apb     = UFC_ACCESS;
          st_next.pready  = 1'b1;
          st_next.pslverr = !addr_ok(paddr);
          st_next.prdata  = 32'h0000_0000;
          case (paddr)
            UFC_OFF_FIFO_CONTROL: st_next.prdata[7:0] = ctrl_rd;
            UFC_OFF_RX_IRQ_LEVEL: st_next.prdata[7:0] = st_reg.levels.rx_irq;
            UFC_OFF_TX_IRQ_LEVEL: st_next.prdata[7:0] = st_reg.levels.tx_irq;
            UFC_OFF_FLOW_HIGH:    st_next.prdata[7:0] = st_reg.levels.flow_high;
            UFC_OFF_FLOW_LOW:     st_next.prdata[7:0] = st_reg.levels.flow_low;
            UFC_OFF_STATUS:       st_next.prdata[3:0] = {tx_emp, rx_rdy,
                                    |st_reg.levels, st_reg.ctrl[UFC_BIT_ENABLE]};
            UFC_OFF_IRQ_STATUS:   st_next.prdata[3:0] = st_reg.irq_stat;
            UFC_OFF_IRQ_MASK:     st_next.prdata[3:0] = st_reg.irq_mask;
            UFC_OFF_THRESH:       st_next.prdata[15:0] = {thresh.tx, thresh.rx};
            default:              st_next.prdata = 32'h0000_0000;
          endcase
        end
      end
      UFC_ACCESS:
      begin
        st_next.apb = UFC_IDLE;
      end
      default:
      begin
        st_next.apb = UFC_IDLE;
      end
    endcase

    // Register writes take effect at the access edge
    st_next.rx_clr = 1'b0;
    st_next.tx_clr = 1'b0;
    if (wr)
    begin
      case (paddr)
        UFC_OFF_FIFO_CONTROL:
        begin
          // Reserved bit three is stored but steers nothing
          st_next.ctrl = pwdata[7:0];
          st_next.ctrl[UFC_BIT_RX_CLEAR] = 1'b0;
          st_next.ctrl[UFC_BIT_TX_CLEAR] = 1'b0;
          st_next.rx_clr = pwdata[UFC_BIT_RX_CLEAR];
          st_next.tx_clr = pwdata[UFC_BIT_TX_CLEAR];
        end
        UFC_OFF_RX_IRQ_LEVEL: st_next.levels.rx_irq    = pwdata[7:0];
        UFC_OFF_TX_IRQ_LEVEL: st_next.levels.tx_irq    = pwdata[7:0];
        UFC_OFF_FLOW_HIGH:    st_next.levels.flow_high = pwdata[7:0];
        UFC_OFF_FLOW_LOW:     st_next.levels.flow_low  = pwdata[7:0];
        UFC_OFF_IRQ_MASK:     st_next.irq_mask         = pwdata[3:0];
        default:              st_next.irq_mask         = st_reg.irq_mask;
      endcase
    end

    // Rising edges of the conditions and clear pulses are events
    events = 4'h0;
    events[UFC_EV_RX_READY] = rx_rdy && !st_reg.rx_rdy_d;
    events[UFC_EV_TX_EMPTY] = tx_emp && !st_reg.tx_emp_d;
    events[UFC_EV_RX_CLEAR] = st_reg.rx_clr;
    events[UFC_EV_TX_CLEAR] = st_reg.tx_clr;
    st_next.rx_rdy_d = rx_rdy;
    st_next.tx_emp_d = tx_emp;

    // Read of the status clears it, but a new event wins
    if (rd && paddr == UFC_OFF_IRQ_STATUS)
    begin
      st_next.irq_stat = 4'h0;
    end
    st_next.irq_stat = st_next.irq_stat | events;

    // Registered outputs
    st_next.fifo_en = st_next.ctrl[UFC_BIT_ENABLE];
    st_next.rx_irq  = rx_rdy;
    st_next.tx_irq  = tx_emp;
    st_next.rx_flow = thresh.rx;
    st_next.flow_hi = thresh.flow_high;
    st_next.flow_lo = thresh.flow_low;
    st_next.irq     = |(st_next.irq_stat & st_next.irq_mask);
  end

  // State register; clk_en low freezes everything
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg          <= '0;
      st_reg.apb      <= UFC_IDLE;
      st_reg.ctrl     <= UFC_RST_FIFO_CONTROL;
      st_reg.levels   <= {4{UFC_RST_LEVEL}};
      st_reg.irq_mask <= UFC_RST_MASK;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flip-flops
  assign prdata          = st_reg.prdata;
  assign pready          = st_reg.pready;
  assign pslverr         = st_reg.pslverr;
  assign fifo_enable     = st_reg.fifo_en;
  assign rx_clear        = st_reg.rx_clr;
  assign tx_clear        = st_reg.tx_clr;
  assign rx_ready_irq    = st_reg.rx_irq;
  assign tx_empty_irq    = st_reg.tx_irq;
  assign rx_flow_level   = st_reg.rx_flow;
  assign flow_high_level = st_reg.flow_hi;
  assign flow_low_level  = st_reg.flow_lo;
  assign irq             = st_reg.irq;
endmodule // ufc_fifo_control

// file: hdl/ufc_pkg.sv
// Package: register map, field layout and constants of the FIFO control block
package ufc_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] UFC_OFF_FIFO_CONTROL = 8'h00;
  localparam logic [7:0] UFC_OFF_RX_IRQ_LEVEL = 8'h04;
  localparam logic [7:0] UFC_OFF_TX_IRQ_LEVEL = 8'h08;
  localparam logic [7:0] UFC_OFF_FLOW_HIGH    = 8'h0C;
  localparam logic [7:0] UFC_OFF_FLOW_LOW     = 8'h10;
  localparam logic [7:0] UFC_OFF_STATUS       = 8'h14;
  localparam logic [7:0] UFC_OFF_IRQ_STATUS   = 8'h18;
  localparam logic [7:0] UFC_OFF_IRQ_MASK     = 8'h1C;
  localparam logic [7:0] UFC_OFF_THRESH       = 8'h20;

  // fifo_control field positions
  localparam int UFC_BIT_ENABLE   = 0;
  localparam int UFC_BIT_RX_CLEAR = 1;
  localparam int UFC_BIT_TX_CLEAR = 2;
  localparam int UFC_BIT_RSVD     = 3;
  localparam int UFC_POS_TX_TRIG  = 4;
  localparam int UFC_POS_RX_TRIG  = 6;

  // Reset values
  localparam logic [7:0] UFC_RST_FIFO_CONTROL = 8'h00;
  localparam logic [7:0] UFC_RST_LEVEL        = 8'h00;
  localparam logic [3:0] UFC_RST_MASK         = 4'h0;

  // Trigger levels in 32-byte mode
  localparam logic [7:0] UFC_RX_LVL0 = 8'h08;
  localparam logic [7:0] UFC_RX_LVL1 = 8'h10;
  localparam logic [7:0] UFC_RX_LVL2 = 8'h18;
  localparam logic [7:0] UFC_RX_LVL3 = 8'h1C;
  localparam logic [7:0] UFC_TX_LVL0 = 8'h10;
  localparam logic [7:0] UFC_TX_LVL1 = 8'h08;
  localparam logic [7:0] UFC_TX_LVL2 = 8'h18;
  localparam logic [7:0] UFC_TX_LVL3 = 8'h1E;

  // Event bits in irq status/mask
  localparam int UFC_EV_RX_READY = 0;
  localparam int UFC_EV_TX_EMPTY = 1;
  localparam int UFC_EV_RX_CLEAR = 2;
  localparam int UFC_EV_TX_CLEAR = 3;

  // Levels of the four extended registers
  typedef struct packed {
    logic [7:0] rx_irq;
    logic [7:0] tx_irq;
    logic [7:0] flow_high;
    logic [7:0] flow_low;
  } ufc_levels_t;

  // Selected thresholds
  typedef struct packed {
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] flow_high;
    logic [7:0] flow_low;
  } ufc_thresh_t;

  // APB state
  typedef enum logic [1:0] {
    UFC_IDLE   = 2'b00,
    UFC_ACCESS = 2'b01
  } ufc_apb_state_t;
endpackage : ufc_pkg

// file: hdl/ufc_thresh_sel.sv
// Threshold selector: two-bit fields or the extended level registers
module ufc_thresh_sel
  import ufc_pkg::*;
(
  input  wire logic [7:0]  fifo_control, // Control register value
  input  wire ufc_levels_t levels,       // Extended level registers
  output ufc_thresh_t      thresh        // Selected thresholds
);
  // Receive field decode
  function automatic logic [7:0] rx_decode(input logic [1:0] f);
    case (f)
      2'b00:   rx_decode = UFC_RX_LVL0;
      2'b01:   rx_decode = UFC_RX_LVL1;
      2'b10:   rx_decode = UFC_RX_LVL2;
      default: rx_decode = UFC_RX_LVL3;
    endcase
  endfunction

  // Transmit field decode; note the non-monotonic order
  function automatic logic [7:0] tx_decode(input logic [1:0] f);
    case (f)
      2'b00:   tx_decode = UFC_TX_LVL0;
      2'b01:   tx_decode = UFC_TX_LVL1;
      2'b10:   tx_decode = UFC_TX_LVL2;
      default: tx_decode = UFC_TX_LVL3;
    endcase
  endfunction

  logic ext_mode;
  logic [7:0] rx_fld;
  logic [7:0] tx_fld;

  // Any nonzero extended register overrides both fields
  always_comb
  begin
    ext_mode = |levels;
    rx_fld   = rx_decode(fifo_control[UFC_POS_RX_TRIG +: 2]);
    tx_fld   = tx_decode(fifo_control[UFC_POS_TX_TRIG +: 2]);
    if (ext_mode)
    begin
      thresh.rx        = levels.rx_irq;
      thresh.tx        = levels.tx_irq;
      thresh.flow_high = levels.flow_high;
      thresh.flow_low  = levels.flow_low;
    end
    else
    begin
      // Flow control compares against the same trigger levels
      thresh.rx        = rx_fld;
      thresh.tx        = tx_fld;
      thresh.flow_high = rx_fld;
      thresh.flow_low  = tx_fld;
    end
  end
endmodule // ufc_thresh_sel

// file: verification/ufc_fifo_control_bench.sv
// Testbench: APB register traffic, FIFO thresholds and interrupts
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module ufc_fifo_control_bench
  import ufc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, ld, pready, pslverr, irq;
  logic        fifo_enable, rx_clear, tx_clear, rx_ready_irq, tx_empty_irq, clk_en;
  logic [7:0]  paddr, rx_d, tx_d, rx_count, tx_count, rx_flow_level, fh, fl;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [33:0] q[$];
  logic [7:0]  rxl[4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
  logic [7:0]  txl[4] = '{8'h10, 8'h08, 8'h18, 8'h1E};
  int          checks = 0, miscompares = 0, seed = 27, n;
  ufc_fifo_control ufc_fifo_control_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_count(rx_count), .tx_count(tx_count), .fifo_enable(fifo_enable),
    .rx_clear(rx_clear), .tx_clear(tx_clear), .rx_ready_irq(rx_ready_irq),
    .tx_empty_irq(tx_empty_irq), .rx_flow_level(rx_flow_level), .flow_high_level(fh),
    .flow_low_level(fl), .irq(irq));
  ufc_fifo_model ufc_fifo_model_i (.pclk(pclk), .presetn(presetn), .ld(ld), .rx_d(rx_d),
    .tx_d(tx_d), .rx_clear(rx_clear), .tx_clear(tx_clear), .rx_count(rx_count),
    .tx_count(tx_count));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task test_done;
  begin
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Expectation bits: check flag, error flag, data; reads queue it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
  begin
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin miscompares++; test_done; end
    psel <= 1'b0; penable <= 1'b0;
  end
  endtask
  // Loads fill counts; the model and the design each add one register
  task lv(input logic [7:0] rc, input logic [7:0] tc);
  begin
    @(posedge pclk);
    ld <= 1'b1; rx_d <= rc; tx_d <= tc;
    @(posedge pclk);
    ld <= 1'b0;
    repeat (3) @(posedge pclk);
  end
  endtask
  // Read monitor takes the oldest expectation when an answer appears
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (q.size() == 0) miscompares++;
      else begin r = 0; if (q[0][33]) `CHK({pslverr, prdata}, q[0][32:0]) void'(q.pop_front()); end
    end
  initial
  begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pstrb = 4'hF; ld = 0; rx_d = 0; tx_d = 0; clk_en = 1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, UFC_OFF_FIFO_CONTROL, 0, {1'b1, 33'h0});
    `CHK(tx_empty_irq, 1'b0)
    $display("test reset done");
    for (int t = 0; t < 4; t++)
    begin
      apb(1, UFC_OFF_FIFO_CONTROL, {t[1:0], t[1:0], 4'h1}, 0);
      apb(0, UFC_OFF_THRESH, 0, {2'b10, 16'h0, txl[t], rxl[t]});
      lv(rxl[t] - 8'h01, txl[t]);
      `CHK(rx_ready_irq, 1'b0)
      `CHK(tx_empty_irq, 1'b0)
      `CHK(rx_flow_level, rxl[t])
      lv(rxl[t], txl[t] - 8'h01);
      `CHK(rx_ready_irq, 1'b1)
      `CHK(tx_empty_irq, 1'b1)
    end
    `CHK({fh, fl}, {rxl[3], txl[3]})
    $display("test triggers done");
    apb(1, UFC_OFF_FIFO_CONTROL, 8'hC7, 0);
    apb(0, UFC_OFF_FIFO_CONTROL, 0, {2'b10, 32'hC1});
    `CHK({rx_count, tx_count}, 16'h0000)
    apb(1, UFC_OFF_FIFO_CONTROL, 8'h09, 0);
    pstrb <= 4'h0;
    apb(1, UFC_OFF_FIFO_CONTROL, 8'h00, 0);
    pstrb <= 4'hF;
    apb(0, UFC_OFF_FIFO_CONTROL, 0, {2'b10, 32'h09});
    apb(0, UFC_OFF_THRESH, 0, {2'b10, 16'h0, txl[0], rxl[0]});
    `CHK(fifo_enable, 1'b1)
    apb(1, UFC_OFF_RX_IRQ_LEVEL, 5, 0);
    apb(1, UFC_OFF_FLOW_HIGH, 3, 0);
    apb(0, UFC_OFF_THRESH, 0, {2'b10, 32'h0005});
    `CHK({rx_flow_level, fh}, 16'h0503)
    apb(1, UFC_OFF_RX_IRQ_LEVEL, 0, 0);
    apb(1, UFC_OFF_FLOW_HIGH, 0, 0);
    apb(0, 8'h40, 0, {2'b11, 32'h0});
    $display("test clear and modes done");
    apb(1, UFC_OFF_IRQ_MASK, 1, 0);
    lv(0, 16);
    apb(0, UFC_OFF_IRQ_STATUS, 0, 0);
    lv(8, 16);
    `CHK(irq, 1'b1)
    apb(0, UFC_OFF_IRQ_STATUS, 0, {2'b10, 32'h1});
    // The read clear lands at the access edge; look once it has settled
    @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1, UFC_OFF_IRQ_MASK, 0, 0);
    lv(0, 16);
    lv(8, 16);
    `CHK(irq, 1'b0)
    // Clock enable low freezes the receive-ready level though the fill drops
    clk_en <= 1'b0;
    lv(0, 16);
    `CHK(rx_ready_irq, 1'b1)
    clk_en <= 1'b1;
    $display("test interrupt done");
    repeat (20)
    begin
      r = $random(seed);
      lv({3'b0, r[4:0]}, 16);
      `CHK(rx_ready_irq, r[4:0] >= 5'd8)
    end
    $display("test random done");
    test_done;
  end
endmodule // ufc_fifo_control_bench

// file: verification/ufc_fifo_control_chk.sv
// Checker: port-level properties of the FIFO control block
module ufc_fifo_control_chk
  import ufc_pkg::*;
(
  input wire logic        pclk,          // Clock
  input wire logic        presetn,       // Reset, active low
  input wire logic        clk_en,        // Run enable
  input wire logic        psel,          // APB select
  input wire logic        penable,       // APB enable
  input wire logic        pwrite,        // APB direction
  input wire logic [7:0]  paddr,         // APB address
  input wire logic [31:0] pwdata,        // APB write data
  input wire logic [3:0]  pstrb,         // APB strobes
  input wire logic        pready,        // APB ready
  input wire logic [7:0]  rx_count,      // Receive fill
  input wire logic        fifo_enable,   // FIFOs on
  input wire logic        rx_clear,      // Receive clear
  input wire logic        tx_clear,      // Transmit clear
  input wire logic        rx_ready_irq,  // Receive ready
  input wire logic        tx_empty_irq,  // Transmit empty
  input wire logic [7:0]  rx_flow_level  // Receive threshold
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted control write; clears may only follow such a write
  logic ctl_wr;
  logic ctl_rx;
  logic wr_en;
  assign ctl_wr = psel && penable && pready && pwrite && clk_en && pstrb[0]
                  && paddr == UFC_OFF_FIFO_CONTROL;
  assign ctl_rx = ctl_wr && pwdata[UFC_BIT_RX_CLEAR];
  assign wr_en  = pwdata[UFC_BIT_ENABLE];
  property p_rx_pulse; rx_clear |=> !rx_clear; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx clear too long");
  property p_tx_pulse; tx_clear |=> !tx_clear; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx clear too long");
  property p_rx_wr; ctl_rx |=> rx_clear; endproperty
  a_rx_wr: assert property (p_rx_wr) else $error("rx clear late");
  property p_tx_wr; ctl_wr && pwdata[UFC_BIT_TX_CLEAR] |=> tx_clear; endproperty
  a_tx_wr: assert property (p_tx_wr) else $error("tx clear late");
  property p_rx_src; $rose(rx_clear) |-> $past(ctl_rx); endproperty
  a_rx_src: assert property (p_rx_src) else $error("rx clear unasked");
  property p_en_wr; ctl_wr |=> fifo_enable == $past(wr_en); endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable not taken");
  property p_tx_off; tx_empty_irq |-> $past(fifo_enable); endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx empty while off");
  // Compared only once inputs settle, since rx_ready_irq lags its inputs one cycle
  property p_rx_lvl;
    $past(clk_en) && $stable(rx_count) && $stable(rx_flow_level) && $stable(fifo_enable)
    && !$past(rx_clear) && !rx_clear
    |-> rx_ready_irq == (fifo_enable && rx_count >= rx_flow_level);
  endproperty
  a_rx_lvl: assert property (p_rx_lvl) else $error("rx ready wrong");
  c_clr: cover property (ctl_rx);
  c_rx: cover property ($rose(rx_ready_irq));
  c_tx: cover property ($rose(tx_empty_irq));
endmodule // ufc_fifo_control_chk

bind ufc_fifo_control ufc_fifo_control_chk ufc_fifo_control_chk_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .rx_count(rx_count), .fifo_enable(fifo_enable), .rx_clear(rx_clear),
  .tx_clear(tx_clear), .rx_ready_irq(rx_ready_irq), .tx_empty_irq(tx_empty_irq),
  .rx_flow_level(rx_flow_level));

// file: verification/ufc_fifo_model.sv
// Partner model: receive and transmit FIFO fill counters
module ufc_fifo_model
(
  input  wire logic       pclk,      // Clock
  input  wire logic       presetn,   // Reset, active low
  input  wire logic       ld,        // Load new fill counts
  input  wire logic [7:0] rx_d,      // Receive fill to load
  input  wire logic [7:0] tx_d,      // Transmit fill to load
  input  wire logic       rx_clear,  // Empty receive FIFO
  input  wire logic       tx_clear,  // Empty transmit FIFO
  output logic      [7:0] rx_count,  // Receive fill
  output logic      [7:0] tx_count   // Transmit fill
);
  timeunit 1ns;
  timeprecision 1ps;
  // A clear beats a load in the same cycle, as a real FIFO reset would
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_count <= 8'h00;
      tx_count <= 8'h00;
    end
    else
    begin
      if (ld) rx_count <= rx_d;
      if (ld) tx_count <= tx_d;
      if (rx_clear) rx_count <= 8'h00;
      if (tx_clear) tx_count <= 8'h00;
    end
  end
endmodule // ufc_fifo_model
